// ===== pkg/smd_pkg.sv
// Purpose: constants and types for the shift/move execution datapath
// Assumes: 8-bit data, 7-bit in-bank file address
// Notes: operation codes are local to this block's decoder handshake
package smd_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int DATA_MSB = 7;
    localparam int PTR_MSB = 15;
    localparam int PTR_W = 16;
    localparam logic [1:0] OP_LSL = 2'h0;
    localparam logic [1:0] OP_LSR = 2'h1;
    localparam logic [1:0] OP_MOV = 2'h2;
    localparam logic [1:0] OP_OTHER = 2'h3;
    localparam logic DEST_W = 1'h0;
    localparam logic DEST_F = 1'h1;
    localparam logic [7:0] WREG_RESET = 8'h00;
    localparam logic [2:0] BASE_CYCLES = 3'h1;

    typedef enum logic [3:0] {
        SMD_IDLE = 4'h1,
        SMD_EXEC = 4'h2,
        SMD_EXTRA = 4'h4,
        SMD_NOP = 4'h8
    } smd_state_t;
endpackage

// ===== src/smd_shift_move_datapath.sv
// Purpose: execute logical shifts and file moves, count instruction cycles
// Assumes: decoder pulses issue for one clock and holds operands until done; one instruction cycle = one clock
// Notes: cycle stretching also serves other instructions via redirect flag
// Function
// [RQ1] a PC change or a true test makes an instruction take two cycles.
// [RQ2] that second cycle performs no operation.
// [RQ3] addressing the indirect register with pointer MSb set adds one cycle.
// [RQ4] left shift: bit 7 to carry, bits 6:0 up one, bit 0 cleared, C Z set.
// [RQ5] right shift: bit 0 to carry, bits 7:1 down, bit 7 cleared, C Z set.
// [RQ6] dest select 0 writes the working register, 1 the file register.
// [RQ7] move copies the file register to the destination, sets Z, one cycle.
// [RQ8] the file operand is a 7-bit in-bank address from 0 to 127.
`timescale 1ns/10ps
module smd_shift_move_datapath
    import smd_pkg::*;
#(
    parameter logic [ADDR_W-1:0] INDIRECT_ADDR = 7'h00
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic issue,
    input wire logic [1:0] opCode,
    input wire logic destSel,
    input wire logic [ADDR_W-1:0] fileAddr,
    input wire logic [DATA_W-1:0] fileData,
    input wire logic [PTR_W-1:0] indirectPointer,
    input wire logic pcRedirect,
    output logic busy,
    output logic done,
    output logic [ADDR_W-1:0] fileWrAddr,
    output logic [DATA_W-1:0] fileWrData,
    output logic fileWrEn,
    output logic [DATA_W-1:0] workReg,
    output logic carryFlag,
    output logic zeroFlag,
    output logic [2:0] cycleCount
);
    // ==========================================================
    // result computation
    // ==========================================================
    logic [DATA_W-1:0] result;
    logic carryOut;
    logic touchCarry;
    logic indirectHit;

    always_comb
    begin
        result = fileData;
        carryOut = carryFlag;
        touchCarry = 1'b0;
        case (opCode)
            OP_LSL:
            begin
                result = {fileData[DATA_MSB-1:0], 1'b0}; // RQ4
                carryOut = fileData[DATA_MSB]; // RQ4
                touchCarry = 1'b1;
            end
            OP_LSR:
            begin
                result = {1'b0, fileData[DATA_MSB:1]}; // RQ5
                carryOut = fileData[0]; // RQ5
                touchCarry = 1'b1;
            end
            default:
            begin
                result = fileData; // RQ7
            end
        endcase
    end

    // file operand is the in-bank 7-bit address
    assign indirectHit = (fileAddr == INDIRECT_ADDR)
        && indirectPointer[PTR_MSB]; // RQ3 RQ8

    // ==========================================================
    // sequencer
    // ==========================================================
    smd_state_t state_q, state_d;
    logic needExtra_q, needExtra_d;
    logic needNop_q, needNop_d;
    logic [2:0] count_q, count_d;
    logic [DATA_W-1:0] work_q, work_d;
    logic carry_q, carry_d, zero_q, zero_d;
    logic [ADDR_W-1:0] wrAddr_q, wrAddr_d;
    logic [DATA_W-1:0] wrData_q, wrData_d;
    logic wrEn_q, wrEn_d;
    logic done_q, done_d;
    logic execNow;

    always_comb
    begin
        state_d = state_q;
        needExtra_d = needExtra_q;
        needNop_d = needNop_q;
        count_d = count_q;
        work_d = work_q;
        carry_d = carry_q;
        zero_d = zero_q;
        wrAddr_d = wrAddr_q;
        wrData_d = wrData_q;
        wrEn_d = 1'b0;
        done_d = 1'b0;
        execNow = 1'b0;
        case (state_q)
            SMD_IDLE:
            begin
                if (issue)
                begin
                    needExtra_d = indirectHit;
                    needNop_d = pcRedirect;
                    count_d = BASE_CYCLES;
                    state_d = indirectHit ? SMD_EXTRA : SMD_EXEC; // RQ3
                end
            end
            SMD_EXTRA:
            begin
                count_d = count_q + 3'h1; // RQ3
                state_d = SMD_EXEC;
            end
            SMD_EXEC:
            begin
                execNow = 1'b1;
                if (opCode != OP_OTHER)
                begin
                    if (destSel == DEST_W)
                        work_d = result; // RQ6
                    else
                    begin
                        wrEn_d = 1'b1; // RQ6
                        wrAddr_d = fileAddr;
                        wrData_d = result;
                    end
                    zero_d = (result == 8'h00); // RQ7
                    if (touchCarry)
                        carry_d = carryOut;
                end
                if (needNop_q)
                begin
                    count_d = count_q + 3'h1; // RQ1
                    state_d = SMD_NOP;
                end
                else
                begin
                    done_d = 1'b1;
                    state_d = SMD_IDLE;
                end
            end
            SMD_NOP:
            begin
                done_d = 1'b1; // RQ2
                state_d = SMD_IDLE;
            end
            default:
            begin
                state_d = SMD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= SMD_IDLE;
            needExtra_q <= 1'b0;
            needNop_q <= 1'b0;
            count_q <= 3'h0;
            work_q <= WREG_RESET;
            carry_q <= 1'b0;
            zero_q <= 1'b0;
            wrAddr_q <= 7'h00;
            wrData_q <= 8'h00;
            wrEn_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            needExtra_q <= needExtra_d;
            needNop_q <= needNop_d;
            count_q <= count_d;
            work_q <= work_d;
            carry_q <= carry_d;
            zero_q <= zero_d;
            wrAddr_q <= wrAddr_d;
            wrData_q <= wrData_d;
            wrEn_q <= wrEn_d;
            done_q <= done_d;
        end
    end

    assign busy = (state_q != SMD_IDLE);
    assign done = done_q;
    assign fileWrAddr = wrAddr_q;
    assign fileWrData = wrData_q;
    assign fileWrEn = wrEn_q;
    assign workReg = work_q;
    assign carryFlag = carry_q;
    assign zeroFlag = zero_q;
    assign cycleCount = count_q;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    chk_nop_no_write: assert property ( // RQ2
        state_q == SMD_NOP |=> !fileWrEn && $stable(workReg)
            && $stable(carryFlag) && $stable(zeroFlag))
        else $error("write during no-op cycle");
    chk_redirect_two: assert property ( // RQ1
        state_q == SMD_IDLE && issue && pcRedirect && !indirectHit
        |-> ##3 done && cycleCount == 3'h2)
        else $error("redirect did not take two cycles");
    chk_plain_one: assert property ( // RQ7
        state_q == SMD_IDLE && issue && !pcRedirect && !indirectHit
        |-> ##2 done && cycleCount == 3'h1)
        else $error("plain instruction not one cycle");
    chk_indirect_extra: assert property ( // RQ3
        state_q == SMD_IDLE && issue && indirectHit && !pcRedirect
        |-> ##3 done && cycleCount == 3'h2)
        else $error("indirect access missing extra cycle");
    chk_lsl_carry: assert property ( // RQ4
        execNow && opCode == OP_LSL
        |=> carryFlag == $past(fileData[7])
            && zeroFlag == ($past(fileData[6:0]) == 7'h00))
        else $error("left shift flags wrong");
    chk_lsr_carry: assert property ( // RQ5
        execNow && opCode == OP_LSR
        |=> carryFlag == $past(fileData[0])
            && zeroFlag == ($past(fileData[7:1]) == 7'h00))
        else $error("right shift flags wrong");
    chk_dest_file: assert property ( // RQ6
        execNow && opCode != OP_OTHER && destSel == DEST_F
        |=> fileWrEn && fileWrAddr == $past(fileAddr)
            && $stable(workReg))
        else $error("file destination not written");
    chk_dest_work: assert property ( // RQ6
        execNow && opCode == OP_MOV && destSel == DEST_W
        |=> !fileWrEn && workReg == $past(fileData))
        else $error("move to working register wrong");
    chk_lsl_data: assert property ( // RQ4
        execNow && opCode == OP_LSL && destSel == DEST_F
        |=> fileWrData == {$past(fileData[6:0]), 1'b0})
        else $error("left shift data wrong");

    cov_redirect: cover property (state_q == SMD_NOP);
    cov_indirect: cover property (state_q == SMD_EXTRA);
    cov_both: cover property (state_q == SMD_EXTRA && needNop_q);
    cov_move_w: cover property (execNow && opCode == OP_MOV && !destSel);
    cov_extra_nop: cover property (state_q == SMD_NOP && needExtra_q);
endmodule // smd_shift_move_datapath

// ===== verif/smd_file_space.sv
// Purpose: file register space model facing the datapath
// Assumes: reads are combinational, writes land on the rising edge
// Notes: the bench preloads bytes with poke while the datapath is idle
`timescale 1ns/10ps
module smd_file_space
    import smd_pkg::*;
(
    input wire logic clock,
    input wire logic [ADDR_W-1:0] fileAddr,
    output logic [DATA_W-1:0] fileData,
    input wire logic [ADDR_W-1:0] fileWrAddr,
    input wire logic [DATA_W-1:0] fileWrData,
    input wire logic fileWrEn
);
    // ==========================================
    // storage
    logic [DATA_W-1:0] mem [0:127];
    initial
    begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'h00;
    end
    assign fileData = mem[fileAddr];
    always @(posedge clock)
    begin
        if (fileWrEn === 1'b1)
            mem[fileWrAddr] <= fileWrData;
    end
    task automatic poke(input logic [6:0] a, input logic [7:0] v);
        mem[a] = v;
    endtask
endmodule // smd_file_space

// ===== verif/smd_shift_move_datapath_bench.sv
// Purpose: self-checking bench for the shift/move datapath
// Assumes: one instruction in flight, driver waits for done
// Notes: expectations are queued by the driver, popped at done
`timescale 1ns/10ps
module smd_shift_move_datapath_bench;
    import smd_pkg::*;
    typedef struct {logic wr; logic [6:0] addr; logic [7:0] data;
        logic [7:0] w; logic c; logic z; logic [2:0] cyc;} smd_note_t;
    logic clock = 1'b0, reset_n = 1'b0, issue = 1'b0, destSel = 1'b0;
    logic pcRedirect = 1'b0, busy, done, fileWrEn, carryFlag, zeroFlag;
    logic [1:0] opCode = 2'h0;
    logic [6:0] fileAddr = 7'h00, fileWrAddr, wrAddr;
    logic [7:0] fileData, fileWrData, workReg, wrData, wrCount = 8'h00;
    logic [7:0] shadow [0:127];
    logic [15:0] indirectPointer = 16'h0000;
    logic [2:0] cycleCount;
    logic [7:0] wExp = 8'h00;
    logic cExp = 1'b0, zExp = 1'b0;
    smd_note_t notes[$];
    smd_note_t nt;
    int mismatches = 0, nTests = 0, seed = 17;
    always #4 clock = ~clock;
    smd_shift_move_datapath #(.INDIRECT_ADDR(7'h00)) DUT (.clock(clock),
        .reset_n(reset_n), .issue(issue), .opCode(opCode),
        .destSel(destSel), .fileAddr(fileAddr), .fileData(fileData),
        .indirectPointer(indirectPointer), .pcRedirect(pcRedirect),
        .busy(busy), .done(done), .fileWrAddr(fileWrAddr),
        .fileWrData(fileWrData), .fileWrEn(fileWrEn), .workReg(workReg),
        .carryFlag(carryFlag), .zeroFlag(zeroFlag), .cycleCount(cycleCount));
    smd_file_space fileSpace (.clock(clock), .fileAddr(fileAddr),
        .fileData(fileData), .fileWrAddr(fileWrAddr),
        .fileWrData(fileWrData), .fileWrEn(fileWrEn));
    // ==========================================
    // tasks
    task automatic summarize();
        if (mismatches == 0 && nTests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic checkVal(input string what, input logic [7:0] e,
        input logic [7:0] g);
        nTests++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic setFile(input logic [6:0] a, input logic [7:0] v);
        // let a pending write of the last instruction land first
        @(posedge clock);
        #1;
        shadow[a] = v;
        fileSpace.poke(a, v);
    endtask
    task automatic execInstr(input logic [1:0] op, input logic d,
        input logic [6:0] a, input logic r, input logic p);
        smd_note_t n;
        logic [7:0] s;
        int k;
        s = shadow[a];
        n.data = s;
        if (op == OP_LSL)
            {cExp, n.data} = {s, 1'b0};
        if (op == OP_LSR)
            {n.data, cExp} = {1'b0, s};
        n.wr = (op != OP_OTHER) && (d == DEST_F);
        if (op != OP_OTHER)
            zExp = (n.data == 8'h00);
        if (n.wr)
            shadow[a] = n.data;
        if (op != OP_OTHER && d == DEST_W)
            wExp = n.data;
        n.addr = a;
        n.w = wExp;
        n.c = cExp;
        n.z = zExp;
        n.cyc = 3'h1 + {2'h0, r} + {2'h0, (a == 7'h00) && p};
        notes.push_back(n);
        @(posedge clock);
        #1;
        {opCode, destSel, fileAddr, pcRedirect} = {op, d, a, r};
        indirectPointer = {p, 15'($random(seed))};
        issue = 1'b1;
        @(posedge clock);
        #1;
        issue = 1'b0;
        checkVal("busy", 8'h01, {7'h0, busy});
        k = 0;
        while (done !== 1'b1 && k < 12)
        begin
            @(posedge clock);
            #1;
            k++;
        end
        if (k == 12)
            checkVal("done", 8'h01, 8'h00);
    endtask
    // ==========================================
    // monitor
    always @(posedge clock)
    begin
        if (fileWrEn === 1'b1)
        begin
            wrCount = wrCount + 8'h01;
            wrAddr = fileWrAddr;
            wrData = fileWrData;
        end
        if (done === 1'b1)
        begin
            nt = notes.pop_front();
            checkVal("workReg", nt.w, workReg);
            checkVal("busy", 8'h00, {7'h0, busy});
            checkVal("carryFlag", {7'h0, nt.c}, {7'h0, carryFlag});
            checkVal("zeroFlag", {7'h0, nt.z}, {7'h0, zeroFlag});
            checkVal("cycleCount", {5'h0, nt.cyc}, {5'h0, cycleCount});
            checkVal("writeCount", {7'h0, nt.wr}, wrCount);
            if (nt.wr)
            begin
                checkVal("fileWrAddr", {1'b0, nt.addr}, {1'b0, wrAddr});
                checkVal("fileWrData", nt.data, wrData);
            end
            wrCount = 8'h00;
        end
    end
    // ==========================================
    // stimulus
    initial
    begin
        for (int i = 0; i < 128; i++)
            shadow[i] = 8'h00;
        repeat (10) @(posedge clock);
        #1;
        reset_n = 1'b1;
        setFile(7'h7f, 8'h81);
        for (int i = 0; i < 8; i++)
            execInstr(2'(i / 2), i[0], 7'h7f, 1'b0, 1'b0);
        setFile(7'h10, 8'h80);
        execInstr(OP_LSL, DEST_W, 7'h10, 1'b0, 1'b0);
        setFile(7'h11, 8'h01);
        execInstr(OP_LSR, DEST_F, 7'h11, 1'b0, 1'b0);
        execInstr(OP_MOV, DEST_F, 7'h11, 1'b1, 1'b0);
        execInstr(OP_OTHER, DEST_W, 7'h00, 1'b1, 1'b1);
        execInstr(OP_LSL, DEST_F, 7'h00, 1'b0, 1'b1);
        execInstr(OP_LSR, DEST_W, 7'h05, 1'b0, 1'b1);
        for (int i = 0; i < 80; i++)
        begin
            logic [6:0] ra;
            ra = ($random(seed) & 3) == 0 ? 7'h00 : 7'($random(seed));
            if ($random(seed) & 1)
                setFile(ra, 8'($random(seed)));
            execInstr(2'($random(seed)), 1'($random(seed)), ra,
                1'($random(seed)), 1'($random(seed)));
        end
        repeat (4) @(posedge clock);
        summarize();
    end
    initial
    begin
        #100000;
        mismatches++;
        summarize();
    end
endmodule // smd_shift_move_datapath_bench
